// ---- adcs_consts.svh ----
// adcs_consts.svh: offsets, codes, field positions and timing counts
// of the converter control and its two-wire master.
// assumes a 100 MHz system clock on both ends.
`ifndef ADCS_CONSTS_SVH
`define ADCS_CONSTS_SVH

`define ADCS_CLK_MHZ        100
`define ADCS_CONV_TIME_US   1000
`define ADCS_SCL_KHZ        100
`define ADCS_CONV_CNT_W     24
`define ADCS_GLOBAL_ADDR    7'h77
`define ADCS_SEL_ENABLE     3'h5
`define ADCS_SEL_DEFAULT    5'h00
`define ADCS_COMMON_CH      5'h10
`define ADCS_RESULT_BITS    5'h18
`define ADCS_BYTE_BITS      4'h8
`define ADCS_LVL_LOW        2'h0
`define ADCS_LVL_HIGH       2'h1
`define ADCS_LVL_FLOAT      2'h2

`endif

// ---- adcs_pkg.sv ----
// adcs_pkg: state types of the converter control and its master.
// assumes adcs_consts.svh is on the include path.
`include "adcs_consts.svh"

package adcs_pkg;

  typedef enum logic [2:0] {DB_IDLE, DB_ADDR, DB_ADDR_ACK, DB_WR, DB_WR_ACK, DB_RD, DB_RD_ACK} adcs_dbus_t;
  typedef enum logic [1:0] {PH_CONV, PH_SLEEP, PH_OUT} adcs_phase_t;
  typedef enum logic [2:0] {HS_IDLE, HS_START, HS_ADDR, HS_WDATA, HS_RDATA, HS_STOP} adcs_hst_t;
  typedef enum logic [1:0] {OP_SYNC, OP_WRITE, OP_READ, OP_WRITE_READ} adcs_op_t;

  typedef struct packed {
    adcs_dbus_t                   bus;
    adcs_phase_t                  phase;
    logic                         scl_s1;
    logic                         scl_s2;
    logic                         scl_d;
    logic                         sda_s1;
    logic                         sda_s2;
    logic                         sda_d;
    logic [5:0]                   pin_s1;
    logic [5:0]                   pin_s2;
    logic [1:0]                   boot;
    logic                         addr_ok;
    logic [6:0]                   own_addr;
    logic [7:0]                   shift;
    logic                         rw;
    logic [3:0]                   cnt;
    logic [4:0]                   sent;
    logic [23:0]                  out_sr;
    logic                         nack_seen;
    logic                         wr_got;
    logic                         wr_acked;
    logic [4:0]                   sel;
    logic [4:0]                   pos_ch;
    logic [4:0]                   neg_ch;
    logic [`ADCS_CONV_CNT_W-1:0]  conv_cnt;
    logic                         busy;
    logic                         conv_start;
    logic                         sda_oe_b;
  } adcs_dev_state_t;

  typedef struct packed {
    adcs_hst_t    st;
    logic [1:0]   q;
    logic [15:0]  tick;
    logic [3:0]   bitn;
    logic [7:0]   tx;
    logic [7:0]   rx;
    logic         ackb;
    adcs_op_t     op;
    logic [6:0]   addr;
    logic [7:0]   wbyte;
    logic [1:0]   rd_len;
    logic [1:0]   nbytes;
    logic         rdph;
    logic         sda_s1;
    logic         sda_s2;
    logic         scl_oe_b;
    logic         sda_oe_b;
    logic [23:0]  result;
    logic         ready;
    logic         done;
    logic         nak;
  } adcs_host_state_t;

endpackage : adcs_pkg

// ---- adcs_link_if.sv ----
// adcs_link_if: the two-wire link between master and converter.
// assumes open-drain wires with pull-ups; levels resolved here.
`timescale 1ns/1ps
`default_nettype none

interface adcs_link_if;
  logic scl_host_out;
  logic scl_host_oe_b;
  logic sda_host_out;
  logic sda_host_oe_b;
  logic sda_dev_out;
  logic sda_dev_oe_b;
  logic scl;
  logic sda;

  // released wire floats high through the pull-up
  assign scl = scl_host_oe_b | scl_host_out;
  assign sda = (sda_host_oe_b | sda_host_out) & (sda_dev_oe_b | sda_dev_out);

  modport dev  (input scl, input sda, output sda_dev_out, output sda_dev_oe_b);
  modport host (input scl, input sda, output scl_host_out, output scl_host_oe_b,
                output sda_host_out, output sda_host_oe_b);
endinterface : adcs_link_if

`default_nettype wire

// ---- adcs_dev.sv ----
// adcs_dev: digital control of the multi-channel converter, a target
// on the two-wire link: channel select, conversion sequencing, result out.
// assumes link wires asynchronous to clk_in; pins and result from analog.
// Notes on behaviour
// [R01] channel command is one whole byte per write
// [R02] power-up selects channel 0/1, starts converting
// [R03] master sends only 000, 100 or 101 preamble
// [R04] preamble 000 or 100 keeps previous channel
// [R05] preamble 101 loads five selection bits
// [R06] first selection bit: differential or single-ended
// [R07] differential pairs 2n, 2n+1; polarity bit swaps
// [R08] single-ended positive is 2n+odd, negative common
// [R09] conversion end enters sleep, awaits read
// [R10] read ack enters output; stop/24 bits converts
// [R11] stop in ack slot aborts read, converts
// [R12] address from three tri-level pins, 27 choices
// [R13] also answer global address 1110111
// [R14] without writes, keep channel, convert after read
// [R15] busy converting: address not acknowledged
// [R16] write then repeated start read is supported
// [R17] after write-read, next conversion uses new channel
// [R18] result: sign, status, 16 bits, six zeros
// [R19] result bits shift out on falling clock
// [R20] global read refused; global write then stop
// [R21] acknowledged write then stop starts conversion
// [R22] tri-level pins latched as address after reset
`timescale 1ns/1ps
`default_nettype none
`include "adcs_consts.svh"

module adcs_dev #(
  parameter int unsigned CONV_CYCLES = `ADCS_CONV_TIME_US * `ADCS_CLK_MHZ
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        ce_in,
  // two-wire link
  adcs_link_if.dev         link,
  // address pins, tri-level from the front end
  input  wire logic [1:0]  addr_pin_0_in,
  input  wire logic [1:0]  addr_pin_1_in,
  input  wire logic [1:0]  addr_pin_2_in,
  // modulator result: sign, status, 16 data bits
  input  wire logic [17:0] result_in,
  // multiplexer and status
  output logic [4:0]       pos_channel_out,
  output logic [4:0]       neg_channel_out,
  output logic             converting_out,
  output logic             conv_start_out
);

  if (CONV_CYCLES < 2 || CONV_CYCLES >= (1 << `ADCS_CONV_CNT_W)) begin : g_bad_conv
    $error("adcs_dev: CONV_CYCLES out of range");
  end

  // target addresses in pin order ca2, ca1, ca0 with low, high, float
  localparam logic [6:0] ADDR_TAB [27] = '{
    7'h14, 7'h16, 7'h15, 7'h26, 7'h34, 7'h27, 7'h17, 7'h25, 7'h24,
    7'h56, 7'h64, 7'h57, 7'h74, 7'h76, 7'h75, 7'h65, 7'h67, 7'h66,
    7'h35, 7'h37, 7'h36, 7'h47, 7'h55, 7'h54, 7'h44, 7'h46, 7'h45
  };

  localparam adcs_pkg::adcs_dev_state_t RST = '{
    bus:      adcs_pkg::DB_IDLE,
    phase:    adcs_pkg::PH_CONV,
    scl_s1:   1'b1,
    scl_s2:   1'b1,
    scl_d:    1'b1,
    sda_s1:   1'b1,
    sda_s2:   1'b1,
    sda_d:    1'b1,
    pin_s1:   6'h00,
    pin_s2:   6'h00,
    boot:     2'h0,
    addr_ok:  1'b0,
    own_addr: 7'h00,
    shift:    8'h00,
    rw:       1'b0,
    cnt:      4'h0,
    sent:     5'h00,
    out_sr:   24'h000000,
    nack_seen: 1'b0,
    wr_got:   1'b0,
    wr_acked: 1'b0,
    sel:      `ADCS_SEL_DEFAULT,
    pos_ch:   5'h00,
    neg_ch:   5'h01,
    conv_cnt: `ADCS_CONV_CNT_W'(CONV_CYCLES),
    busy:     1'b1,
    conv_start: 1'b0,
    sda_oe_b: 1'b1
  };

  // an unused code 3 is read as floating
  function automatic logic [1:0] lvl(input logic [1:0] p);
    lvl = (p > `ADCS_LVL_FLOAT) ? `ADCS_LVL_FLOAT : p;
  endfunction : lvl

  function automatic logic [6:0] addr_decode(input logic [5:0] p);
    logic [4:0] idx;
    idx = 5'(lvl(p[5:4]) * 9 + lvl(p[3:2]) * 3 + lvl(p[1:0]));
    addr_decode = ADDR_TAB[idx];
  endfunction : addr_decode

  // positive input is the same for both modes; only negative differs
  function automatic logic [9:0] mux_pair(input logic [4:0] s);
    logic [4:0] pos;
    logic [4:0] neg;
    pos = {1'b0, s[2:0], s[3]};                              // R07 R08
    neg = s[4] ? `ADCS_COMMON_CH : {1'b0, s[2:0], ~s[3]};    // R06 R07
    mux_pair = {pos, neg};
  endfunction : mux_pair

  adcs_pkg::adcs_dev_state_t r;
  adcs_pkg::adcs_dev_state_t n;

  always_comb begin
    logic go_conv;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic hit;
    go_conv = 1'b0;
    n = r;
    n.conv_start = 1'b0;
    n.scl_s1 = link.scl;
    n.scl_s2 = r.scl_s1;
    n.scl_d  = r.scl_s2;
    n.sda_s1 = link.sda;
    n.sda_s2 = r.sda_s1;
    n.sda_d  = r.sda_s2;
    n.pin_s1 = {addr_pin_2_in, addr_pin_1_in, addr_pin_0_in};
    n.pin_s2 = r.pin_s1;
    rise  = r.scl_s2 & ~r.scl_d;
    fall  = ~r.scl_s2 & r.scl_d;
    start = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
    stop  = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;
    hit   = 1'b0;

    // wait for the pin synchronisers to fill before taking the address
    if (!r.addr_ok) begin
      n.boot = r.boot + 2'h1;
      if (r.boot == 2'h3) begin
        n.own_addr = addr_decode(r.pin_s2);                  // R12 R22
        n.addr_ok  = 1'b1;                                   // R22
      end
    end

    {n.pos_ch, n.neg_ch} = mux_pair(r.sel);

    if (r.phase == adcs_pkg::PH_CONV) begin
      if (r.conv_cnt <= `ADCS_CONV_CNT_W'(1)) begin
        n.phase  = adcs_pkg::PH_SLEEP;                       // R09
        n.busy   = 1'b0;
        n.out_sr = {result_in, 6'h00};                       // R18
      end else begin
        n.conv_cnt = r.conv_cnt - `ADCS_CONV_CNT_W'(1);
      end
    end

    if (stop) begin
      n.bus      = adcs_pkg::DB_IDLE;
      n.sda_oe_b = 1'b1;
      if (r.phase == adcs_pkg::PH_OUT || r.wr_acked) begin
        go_conv = 1'b1;                                      // R10 R11 R21
      end
    end else if (start) begin
      // repeated start keeps phase and the write flag
      n.bus      = adcs_pkg::DB_ADDR;                        // R16
      n.cnt      = 4'h0;
      n.sda_oe_b = 1'b1;
    end else begin
      case (r.bus)
        adcs_pkg::DB_ADDR: begin
          if (rise && r.cnt < `ADCS_BYTE_BITS) begin
            n.shift = {r.shift[6:0], r.sda_s2};
            n.cnt   = r.cnt + 4'h1;
          end else if (fall && r.cnt == `ADCS_BYTE_BITS) begin
            hit = (r.addr_ok && r.shift[7:1] == r.own_addr)  // R12
                  || (r.shift[7:1] == `ADCS_GLOBAL_ADDR && !r.shift[0]); // R13 R20
            if (hit && r.phase != adcs_pkg::PH_CONV) begin   // R15
              n.sda_oe_b = 1'b0;
              n.rw       = r.shift[0];
              n.bus      = adcs_pkg::DB_ADDR_ACK;
              if (!r.shift[0]) begin
                n.wr_acked = 1'b1;                           // R21
                n.wr_got   = 1'b0;
              end
            end else begin
              n.bus = adcs_pkg::DB_IDLE;
            end
          end
        end
        adcs_pkg::DB_ADDR_ACK: begin
          if (fall) begin
            n.cnt = 4'h0;
            if (r.rw) begin
              n.phase    = adcs_pkg::PH_OUT;                 // R10
              n.sent     = 5'h00;
              n.sda_oe_b = r.out_sr[23];                     // R19
              n.out_sr   = {r.out_sr[22:0], 1'b0};
              n.bus      = adcs_pkg::DB_RD;
            end else begin
              n.sda_oe_b = 1'b1;
              n.bus      = adcs_pkg::DB_WR;
            end
          end
        end
        adcs_pkg::DB_WR: begin
          if (rise && r.cnt < `ADCS_BYTE_BITS) begin
            n.shift = {r.shift[6:0], r.sda_s2};
            n.cnt   = r.cnt + 4'h1;
          end else if (fall && r.cnt == `ADCS_BYTE_BITS) begin
            // only one command byte per transfer; extras are refused
            if (!r.wr_got) begin                             // R01
              n.wr_got   = 1'b1;
              n.sda_oe_b = 1'b0;
              n.bus      = adcs_pkg::DB_WR_ACK;
              if (r.shift[7:5] == `ADCS_SEL_ENABLE) begin    // R04 R05
                n.sel = r.shift[4:0];                        // R05 R14 R17
              end
            end else begin
              n.bus = adcs_pkg::DB_IDLE;
            end
          end
        end
        adcs_pkg::DB_WR_ACK: begin
          if (fall) begin
            n.sda_oe_b = 1'b1;
            n.cnt      = 4'h0;
            n.bus      = adcs_pkg::DB_WR;
          end
        end
        adcs_pkg::DB_RD: begin
          if (rise) begin
            n.cnt  = r.cnt + 4'h1;
            n.sent = r.sent + 5'h01;
          end else if (fall) begin
            if (r.cnt == `ADCS_BYTE_BITS) begin
              n.sda_oe_b = 1'b1;
              n.bus      = adcs_pkg::DB_RD_ACK;
            end else begin
              n.sda_oe_b = r.out_sr[23];                     // R19
              n.out_sr   = {r.out_sr[22:0], 1'b0};
            end
          end
        end
        adcs_pkg::DB_RD_ACK: begin
          if (rise) begin
            n.nack_seen = r.sda_s2;
          end else if (fall) begin
            n.cnt = 4'h0;
            if (r.sent == `ADCS_RESULT_BITS) begin
              go_conv = 1'b1;                                // R10 R14 R17
              n.bus   = adcs_pkg::DB_IDLE;
            end else if (r.nack_seen) begin
              // master gave up; output phase lasts until stop
              n.bus = adcs_pkg::DB_IDLE;
            end else begin
              n.sda_oe_b = r.out_sr[23];
              n.out_sr   = {r.out_sr[22:0], 1'b0};
              n.bus      = adcs_pkg::DB_RD;
            end
          end
        end
        default: n.bus = adcs_pkg::DB_IDLE;
      endcase
    end

    if (go_conv) begin
      n.phase      = adcs_pkg::PH_CONV;
      n.busy       = 1'b1;
      n.conv_cnt   = `ADCS_CONV_CNT_W'(CONV_CYCLES);
      n.conv_start = 1'b1;
      n.wr_acked   = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r <= RST;                                              // R02
    end else if (ce_in) begin
      r <= n;
    end
  end

  assign link.sda_dev_out  = 1'b0;
  assign link.sda_dev_oe_b = r.sda_oe_b;
  assign pos_channel_out   = r.pos_ch;
  assign neg_channel_out   = r.neg_ch;
  assign converting_out    = r.busy;
  assign conv_start_out    = r.conv_start;

endmodule : adcs_dev

`default_nettype wire

// ---- adcs_host.sv ----
// adcs_host: two-wire master that writes channel commands and reads
// results of the converter; makes the link clock by dividing clk_in.
// assumes no clock stretching by the target.
`timescale 1ns/1ps
`default_nettype none
`include "adcs_consts.svh"

module adcs_host #(
  parameter int unsigned QTR_CYCLES = (`ADCS_CLK_MHZ * 1000) / (`ADCS_SCL_KHZ * 4)
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  input  wire logic              ce_in,
  // two-wire link
  adcs_link_if.host              link,
  // command side
  input  wire logic              cmd_valid_in,
  input  wire adcs_pkg::adcs_op_t cmd_op_in,
  input  wire logic [6:0]        cmd_addr_in,
  input  wire logic [7:0]        cmd_byte_in,
  input  wire logic [1:0]        cmd_rd_len_in,
  output logic                   cmd_ready_out,
  // answer side
  output logic                   done_out,
  output logic                   nak_out,
  output logic [23:0]            result_out
);

  if (QTR_CYCLES < 1 || QTR_CYCLES > 65535) begin : g_bad_qtr
    $error("adcs_host: QTR_CYCLES out of range");
  end

  adcs_pkg::adcs_host_state_t r;
  adcs_pkg::adcs_host_state_t n;

  always_comb begin
    logic step;
    logic last;
    n = r;
    n.done   = 1'b0;
    n.sda_s1 = link.sda;
    n.sda_s2 = r.sda_s1;
    step = 1'b0;
    last = (2'(r.nbytes + 2'h1) == r.rd_len);
    if (r.st != adcs_pkg::HS_IDLE) begin
      if (r.tick == 16'(QTR_CYCLES - 1)) begin
        n.tick = 16'h0000;
        step   = 1'b1;
      end else begin
        n.tick = r.tick + 16'h0001;
      end
    end
    case (r.st)
      adcs_pkg::HS_IDLE: begin
        if (cmd_valid_in) begin
          n.op     = cmd_op_in;
          n.addr   = cmd_addr_in;
          n.wbyte  = cmd_byte_in;
          n.rd_len = cmd_rd_len_in;
          n.rdph   = (cmd_op_in == adcs_pkg::OP_READ);
          n.nak    = 1'b0;
          n.ready  = 1'b0;
          n.q      = 2'h0;
          n.tick   = 16'h0000;
          n.st     = adcs_pkg::HS_START;
        end
      end
      adcs_pkg::HS_START: begin
        if (step) begin
          n.q = r.q + 2'h1;
          case (r.q)
            2'h0: n.sda_oe_b = 1'b1;
            2'h1: n.scl_oe_b = 1'b1;
            2'h2: n.sda_oe_b = 1'b0;
            default: begin
              n.scl_oe_b = 1'b0;
              n.tx       = {r.addr, r.rdph};
              n.bitn     = 4'h0;
              n.st       = adcs_pkg::HS_ADDR;
            end
          endcase
        end
      end
      adcs_pkg::HS_STOP: begin
        if (step) begin
          n.q = r.q + 2'h1;
          case (r.q)
            2'h0: n.sda_oe_b = 1'b0;
            2'h1: n.scl_oe_b = 1'b1;
            2'h2: n.sda_oe_b = 1'b1;
            default: begin
              n.st    = adcs_pkg::HS_IDLE;
              n.done  = 1'b1;
              n.ready = 1'b1;
            end
          endcase
        end
      end
      default: begin
        // byte engine shared by address, write and read bytes
        if (step) begin
          n.q = r.q + 2'h1;
          case (r.q)
            2'h0: begin
              if (r.bitn < `ADCS_BYTE_BITS) begin
                n.sda_oe_b = (r.st == adcs_pkg::HS_RDATA) ? 1'b1 : r.tx[7];
              end else begin
                // the last read byte is refused so the target lets go
                n.sda_oe_b = (r.st == adcs_pkg::HS_RDATA) ? last : 1'b1;
              end
            end
            2'h1: n.scl_oe_b = 1'b1;
            2'h2: begin
              if (r.bitn < `ADCS_BYTE_BITS) begin
                n.rx = {r.rx[6:0], r.sda_s2};
              end else begin
                n.ackb = r.sda_s2;
              end
            end
            default: begin
              n.scl_oe_b = 1'b0;
              if (r.bitn < `ADCS_BYTE_BITS) begin
                n.tx   = {r.tx[6:0], 1'b0};
                n.bitn = r.bitn + 4'h1;
              end else begin
                n.bitn = 4'h0;
                n.st   = adcs_pkg::HS_STOP;
                case (r.st)
                  adcs_pkg::HS_ADDR: begin
                    if (r.ackb) begin
                      n.nak = 1'b1;
                    end else if (r.rdph) begin
                      n.nbytes = 2'h0;
                      if (r.rd_len != 2'h0) begin
                        n.st = adcs_pkg::HS_RDATA;
                      end
                    end else if (r.op != adcs_pkg::OP_SYNC) begin
                      n.tx = r.wbyte;                        // R01
                      n.st = adcs_pkg::HS_WDATA;
                    end
                  end
                  adcs_pkg::HS_WDATA: begin
                    n.nak = r.ackb;
                    if (!r.ackb && r.op == adcs_pkg::OP_WRITE_READ) begin
                      n.rdph = 1'b1;
                      n.st   = adcs_pkg::HS_START;           // R16
                    end
                  end
                  default: begin
                    n.result = {r.result[15:0], r.rx};
                    n.nbytes = r.nbytes + 2'h1;
                    if (!last) begin
                      n.st = adcs_pkg::HS_RDATA;
                    end
                    // early stop right after the refused ack slot aborts the read
                  end                                        // R11
                endcase
              end
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r <= '{st: adcs_pkg::HS_IDLE, op: adcs_pkg::OP_SYNC, sda_s1: 1'b1, sda_s2: 1'b1,
             scl_oe_b: 1'b1, sda_oe_b: 1'b1, ready: 1'b1, default: '0};
    end else if (ce_in) begin
      r <= n;
    end
  end

  assign link.scl_host_out  = 1'b0;
  assign link.sda_host_out  = 1'b0;
  assign link.scl_host_oe_b = r.scl_oe_b;
  assign link.sda_host_oe_b = r.sda_oe_b;
  assign cmd_ready_out      = r.ready;
  assign done_out           = r.done;
  assign nak_out            = r.nak;
  assign result_out         = r.result;

endmodule : adcs_host

`default_nettype wire

// ---- adcs_chk.sv ----
// adcs_chk: assertions on the link data line and the converter mux outputs.
// assumes master quarter count 8 and the short conversion count given.
`timescale 1ns/1ps
`default_nettype none

module adcs_chk #(
  parameter int unsigned CONV_CYCLES = 200
) (
  // clock and reset
  input wire logic       clk_in,
  input wire logic       rst_b_in,
  // link
  input wire logic       scl,
  input wire logic       sda_dev_oe_b,
  // converter
  input wire logic [4:0] pos_channel_out,
  input wire logic [4:0] neg_channel_out,
  input wire logic       converting_out,
  input wire logic       conv_start_out
);
  logic [15:0] busy_cnt_reg;
  logic [15:0] busy_cnt_next;

  // small margin: sync stages blur the exact start
  always_comb busy_cnt_next = converting_out ? busy_cnt_reg + 16'h0001 : 16'h0000;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_cnt_reg <= 16'h0000;
    end else begin
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  conv_len_a: assert property (busy_cnt_reg <= CONV_CYCLES + 4)
    else $error("conversion ran too long");
  conv_min_a: assert property ($fell(converting_out) |-> busy_cnt_reg + 4 >= CONV_CYCLES)
    else $error("conversion ended early");
  start_pulse_a: assert property (conv_start_out |=> converting_out && !conv_start_out)
    else $error("start pulse malformed");
  start_cause_a: assert property ($rose(converting_out) |-> conv_start_out || $past(conv_start_out))
    else $error("conversion without start pulse");
  diff_pair_a: assert property (neg_channel_out != 5'h10 |-> pos_channel_out[4:1] == neg_channel_out[4:1]
    && pos_channel_out[0] != neg_channel_out[0] && !pos_channel_out[4])
    else $error("differential pair not adjacent");
  single_pos_a: assert property (neg_channel_out == 5'h10 |-> !pos_channel_out[4])
    else $error("single-ended positive out of range");
  mux_hold_a: assert property (converting_out && $past(converting_out) |->
    $stable(pos_channel_out) && $stable(neg_channel_out))
    else $error("channel changed during conversion");
  busy_quiet_a: assert property (converting_out && $past(converting_out, 4) |-> sda_dev_oe_b)
    else $error("data line driven while converting");
  drive_low_a: assert property ($fell(sda_dev_oe_b) |-> !scl)
    else $error("data changed while clock high");
  drive_hold_a: assert property ($fell(sda_dev_oe_b) |=> !sda_dev_oe_b [*8])
    else $error("data bit not held");
endmodule : adcs_chk

`default_nettype wire

// ---- adcs_tb.sv ----
// adcs_tb: master and converter on one link, driven via the master command port.
// assumes short conversion and quarter counts so the run stays brief.
`timescale 1ns/1ps
`default_nettype none

module adcs_tb;
  localparam int unsigned CONV = 500; // outlasts the stop, start and address byte of the next read, so the busy refusal is seen
  localparam logic [17:0] RES = 18'h2A5C3;
  logic clk_in, rst_b_in, cmd_valid, ready, done, nak, conv, start;
  logic [1:0] pin_lvl, cmd_len;
  logic [4:0] pos, neg;
  logic [6:0] cmd_addr, own;
  logic [7:0] cmd_byte;
  logic [23:0] result;
  adcs_pkg::adcs_op_t cmd_op;
  int miscompares, checks;

  adcs_link_if link ();
  adcs_dev #(.CONV_CYCLES(CONV)) adcs_dev_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(1'b1),
    .link(link), .addr_pin_0_in(pin_lvl), .addr_pin_1_in(pin_lvl), .addr_pin_2_in(pin_lvl),
    .result_in(RES), .pos_channel_out(pos), .neg_channel_out(neg), .converting_out(conv),
    .conv_start_out(start));
  adcs_host #(.QTR_CYCLES(8)) adcs_host_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(1'b1),
    .link(link), .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op), .cmd_addr_in(cmd_addr),
    .cmd_byte_in(cmd_byte), .cmd_rd_len_in(cmd_len), .cmd_ready_out(ready), .done_out(done),
    .nak_out(nak), .result_out(result));
  adcs_chk #(.CONV_CYCLES(CONV)) adcs_chk_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .scl(link.scl), .sda_dev_oe_b(link.sda_dev_oe_b), .pos_channel_out(pos),
    .neg_channel_out(neg), .converting_out(conv), .conv_start_out(start));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic hang(input string what);
    chk(what, 24'h0, 24'h1);
    complete_run();
  endtask : hang

  // pos is 2n+odd in both modes; negative is the partner or common
  function automatic logic [23:0] mux(input logic [4:0] c);
    return {14'h0, 1'b0, c[2:0], c[3], c[4] ? 5'h10 : {1'b0, c[2:0], ~c[3]}};
  endfunction : mux

  task automatic xfer(input adcs_pkg::adcs_op_t op, input logic [6:0] a, input logic [7:0] b,
                      input logic [1:0] n);
    int i;
    @(posedge clk_in);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_byte <= b;
    cmd_len <= n;
    @(posedge clk_in);
    cmd_valid <= 1'b0;
    for (i = 0; i < 6000; i++) begin
      @(negedge clk_in);
      if (done === 1'b1) break;
    end
    if (i == 6000) hang("transfer");
    chk("ready", ready, 24'h1);
    // device sync stages lag the master's stop
    repeat (8) @(negedge clk_in);
  endtask : xfer

  task automatic idle();
    int i;
    for (i = 0; i < 1000; i++) begin
      @(negedge clk_in);
      if (conv === 1'b0) break;
    end
    if (i == 1000) hang("conversion");
  endtask : idle

  task automatic boot(input logic [1:0] lvl, input logic [6:0] a);
    pin_lvl <= lvl;
    own = a;
    rst_b_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(negedge clk_in);
    chk("power-up start", conv, 24'h1);
    idle();
    chk("default channel", {14'h0, pos, neg}, {14'h0, 5'h00, 5'h01});
  endtask : boot

  task automatic t_read();
    xfer(adcs_pkg::OP_READ, own ^ 7'h01, 8'h00, 2'h3);
    chk("foreign address", nak, 24'h1);
    xfer(adcs_pkg::OP_READ, own, 8'h00, 2'h3);
    chk("read ack", nak, 24'h0);
    chk("result", result, {RES, 6'h00});
    chk("convert after read", conv, 24'h1);
    xfer(adcs_pkg::OP_READ, own, 8'h00, 2'h3);
    chk("busy refusal", nak, 24'h1);
    idle();
  endtask : t_read

  task automatic t_select();
    for (int c = 0; c < 32; c++) begin
      xfer(adcs_pkg::OP_WRITE, own, {3'b101, c[4:0]}, 2'h0);
      chk("write ack", nak, 24'h0);
      chk("convert on stop", conv, 24'h1);
      chk("channel", {14'h0, pos, neg}, mux(c[4:0]));
      idle();
    end
  endtask : t_select

  task automatic t_keep();
    for (int p = 0; p < 2; p++) begin
      xfer(adcs_pkg::OP_WRITE, own, {p[0], 2'b00, 5'h0A}, 2'h0);
      idle();
      chk("kept channel", {14'h0, pos, neg}, mux(5'h1F));
    end
  endtask : t_keep

  task automatic t_wr_rd();
    xfer(adcs_pkg::OP_WRITE_READ, own, {3'b101, 5'h0B}, 2'h3);
    chk("write-read result", result, {RES, 6'h00});
    chk("write-read channel", {14'h0, pos, neg}, mux(5'h0B));
    idle();
    xfer(adcs_pkg::OP_READ, own, 8'h00, 2'h1);
    chk("first byte", result[7:0], {16'h0, RES[17:10]});
    chk("abort converts", conv, 24'h1);
    idle();
  endtask : t_wr_rd

  task automatic t_global();
    xfer(adcs_pkg::OP_WRITE, 7'h77, {3'b101, 5'h12}, 2'h0);
    chk("global write", nak, 24'h0);
    chk("global channel", {14'h0, pos, neg}, mux(5'h12));
    idle();
    xfer(adcs_pkg::OP_READ, 7'h77, 8'h00, 2'h3);
    chk("global read refused", nak, 24'h1);
    chk("no conversion", conv, 24'h0);
    xfer(adcs_pkg::OP_SYNC, 7'h77, 8'h00, 2'h0);
    chk("global sync", conv, 24'h1);
    idle();
  endtask : t_global

  initial begin
    rst_b_in = 1'b0;
    pin_lvl = 2'h2;
    cmd_valid = 1'b0;
    cmd_op = adcs_pkg::OP_SYNC;
    cmd_addr = 7'h00;
    cmd_byte = 8'h00;
    cmd_len = 2'h0;
    miscompares = 0;
    checks = 0;
    boot(2'h2, 7'h45);
    t_read();
    t_select();
    t_keep();
    t_wr_rd();
    t_global();
    boot(2'h0, 7'h14);
    t_read();
    complete_run();
  end
endmodule : adcs_tb

`default_nettype wire
